// ### g711_pkg.sv
// Constants shared by the companding port unit and its codec modules
package g711_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PORT1 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // Control bit positions
  localparam int TXEN_BIT = 11;
  localparam int ENC_ROUTE_BIT = 12;
  localparam int DEC_ROUTE_BIT = 13;
  localparam int LAW_BIT = 14;
  localparam int NOTATION_BIT = 29;
  // Status field positions
  localparam int STAT_FRONT_LSB = 0;
  localparam int STAT_BACK_LSB = 8;
  localparam int STAT_BUSY_BIT = 16;
  // Reset values
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Companding constants
  localparam logic [15:0] MU_BIAS = 16'h0021;
  localparam logic [15:0] A_HALF_STEP = 16'h0021;
  localparam logic [12:0] MU_CLIP = 13'h1FFF;
  localparam logic [11:0] A_CLIP = 12'hFFF;
  localparam logic [7:0] MU_INVERT = 8'hFF;
  localparam logic [7:0] A_INVERT = 8'h55;
  localparam int MU_SEG_LSB = 5;
  localparam int A_SEG_LSB = 5;
  // Serial frame length in bits
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  // Serial sequencer states
  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;
endpackage

// ### g711_encoder.sv
// Linear to 8-bit log PCM compressor for mu-law and A-law
`timescale 1ns/1ns
module g711_encoder (
  // Linear sample and settings
  input wire logic [15:0] sample,
  input wire logic lawA,
  input wire logic twosComp,
  // Log code
  output logic [7:0] code
);
  logic neg;
  logic [15:0] mag;
  logic [16:0] muMag;
  logic [12:0] muClip;
  logic [11:0] aClip;
  logic [2:0] muSeg;
  logic [2:0] aSeg;
  logic [3:0] muQ;
  logic [3:0] aQ;

  always_comb begin
    neg = sample[15];
    mag = twosComp ? (neg ? ~sample : sample) : {1'b0, sample[14:0]};
    muMag = twosComp ? {1'b0, mag} : {1'b0, mag} + {1'b0, g711_pkg::MU_BIAS}; // RQ1 RQ3
    muClip = (muMag > {4'h0, g711_pkg::MU_CLIP}) ? g711_pkg::MU_CLIP : muMag[12:0]; // RQ16 RQ28
    aClip = (mag > {4'h0, g711_pkg::A_CLIP}) ? g711_pkg::A_CLIP : mag[11:0]; // RQ4 RQ16 RQ28
    muSeg = 3'h0;
    aSeg = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (muClip[i + g711_pkg::MU_SEG_LSB]) muSeg = 3'(i);
    end
    for (int i = 0; i < 7; i++) begin
      if (aClip[i + g711_pkg::A_SEG_LSB]) aSeg = 3'(i + 1);
    end
    muQ = 4'(muClip >> ({1'b0, muSeg} + 4'h1));
    aQ = (aSeg == 3'h0) ? 4'(aClip >> 1) : 4'(aClip >> aSeg);
    // Law picks the format; mu-law codes go out fully inverted
    code = lawA ? ({~neg, aSeg, aQ} ^ g711_pkg::A_INVERT) // RQ17
                : ({neg, muSeg, muQ} ^ g711_pkg::MU_INVERT); // RQ6
  end
endmodule // g711_encoder

// ### g711_decoder.sv
// 8-bit log PCM to linear expander for mu-law and A-law
`timescale 1ns/1ns
module g711_decoder (
  // Log code and settings
  input wire logic [7:0] code,
  input wire logic lawA,
  input wire logic twosComp,
  // Linear result
  output logic [15:0] linear
);
  logic [7:0] raw;
  logic neg;
  logic [15:0] step;
  logic [15:0] mag;

  always_comb begin
    raw = lawA ? (code ^ g711_pkg::A_INVERT) : (code ^ g711_pkg::MU_INVERT); // RQ6 RQ17
    neg = lawA ? ~raw[7] : raw[7];
    step = {11'h000, raw[3:0], 1'b0};
    if (lawA) begin
      mag = (raw[6:4] == 3'h0) ? (step | 16'h0001)
                               : 16'((step + g711_pkg::A_HALF_STEP) << (raw[6:4] - 3'h1)); // RQ4
    end else begin
      mag = 16'((step + g711_pkg::MU_BIAS) << raw[6:4]);
      if (!twosComp) mag = mag - g711_pkg::MU_BIAS; // RQ2 RQ3
    end
    // Sign in the top bit either way
    linear = twosComp ? (neg ? 16'(~mag + 16'h0001) : mag) : {neg, mag[14:0]}; // RQ27
  end
endmodule // g711_decoder

// ### g711_companding_port_unit.sv
// Companding port unit: APB registers, transmit stages, serial shifter
`timescale 1ns/1ns
// Operation
// RQ1 - Sign-magnitude mu-law compression adds a bias of 33 first.
// RQ2 - Sign-magnitude mu-law expansion subtracts a bias of 33 afterwards.
// RQ3 - Two's-complement mu-law uses no extra bias either way.
// RQ4 - A-law never uses a bias correction.
// RQ5 - Reset selects sign-magnitude; software may switch to two's-complement.
// RQ6 - Mu-law codes are fully inverted on transmit and on receive.
// RQ7 - Processor leaves one instruction between port writes and reads in two's-complement.
// RQ8 - All route bits zero: port writes and reads pass data unchanged.
// RQ9 - Transmit enable only: write sends eight bits, read returns received code.
// RQ10 - Parallel encode: write compresses, later read returns that code.
// RQ11 - Serial encode: compressed sample waits in transmit stage for next frame.
// RQ12 - Parallel decode: written code is expanded when port is read.
// RQ13 - Serial decode: read expands received code; all bits set also encodes.
// RQ14 - Parallel encode and decode: write compresses, read expands back.
// RQ15 - Serial setting makes parallel companding unavailable until bits change.
// RQ16 - Encoder handles 14-bit mu-law and 13-bit A-law range.
// RQ17 - Law select zero picks mu-law, one picks A-law.
// RQ18 - Front stage loads encoder result if encoder route set, else low byte.
// RQ19 - Every port write is compressed; only the route bit forwards it.
// RQ20 - Frame moves front stage to shifter; eight bits leave on rising edges.
// RQ21 - Parallel encode read returns the front transmit stage.
// RQ22 - Second write pushes front into back stage; back stage unreadable (the code shows it in the status register, never on port 1).
// RQ23 - Processor issues one write and one read per parallel sample.
// RQ24 - Decoder route zero reads directly, one reads through expander.
// RQ25 - Expander input is receive hold in serial, front stage in parallel.
// RQ26 - Serial outputs are driven only while transmit enable is high.
// RQ27 - Expanded result uses selected notation with sign in top bit.
// RQ28 - Compressor saturates out-of-range magnitudes at the largest code.
module g711_companding_port_unit (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial port
  input wire logic sclk,
  input wire logic frameSync,
  input wire logic rxData,
  output logic txData0,
  output logic txData1,
  output logic txDriveN
);
  // Control bits
  logic transmitEnableBit_reg;
  logic encoderRouteBit_reg;
  logic decoderRouteBit_reg;
  logic lawSelectBit_reg;
  logic notationSelectBit_reg;

  // Transmit stages and receive hold
  logic [7:0] transmitHoldFront_reg;
  logic [7:0] transmitHoldBack_reg;
  logic [7:0] receiveHold_reg;
  logic [7:0] receiveShift_reg;
  logic [7:0] txShift0_reg;
  logic [7:0] txShift1_reg;
  logic [3:0] bitCount_reg;
  logic [3:0] bitCount_next;
  g711_pkg::ser_state_t serState_reg;
  g711_pkg::ser_state_t serState_next;

  // Edge history of the serial inputs
  logic sclkPrev_reg;
  logic framePrev_reg;

  // APB output flops
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Serial output flops
  logic txData0_reg;
  logic txData1_reg;
  logic txDriveN_reg;

  // Decode
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready_reg;
  wire hitControl = paddr == g711_pkg::ADDR_CONTROL;
  wire hitPort1 = paddr == g711_pkg::ADDR_PORT1;
  wire hitStatus = paddr == g711_pkg::ADDR_STATUS;
  wire hitAny = hitControl | hitPort1 | hitStatus;
  wire writeControl = accessDone & pwrite & hitControl;
  wire writePort1 = accessDone & pwrite & hitPort1;

  // Serial edges
  wire sclkRise = sclk & ~sclkPrev_reg;
  wire sclkFall = ~sclk & sclkPrev_reg;
  wire frameStart = frameSync & ~framePrev_reg;
  wire shifting = serState_reg == g711_pkg::SER_SHIFT;
  wire lastBit = sclkFall & (bitCount_reg == g711_pkg::COUNT_ONE);

  // Encoder sees every port write whatever the mode
  wire [7:0] encCode;
  g711_encoder encoder (
    .sample(pwdata[15:0]),
    .lawA(lawSelectBit_reg),
    .twosComp(notationSelectBit_reg),
    .code(encCode)
  ); // RQ19

  // Encoder output selector feeding the front stage
  wire [7:0] frontLoad = encoderRouteBit_reg ? encCode : pwdata[7:0]; // RQ18

  // Serial setting steers reads to the receive side, so parallel paths drop out
  wire [7:0] decodeSource = transmitEnableBit_reg ? receiveHold_reg : transmitHoldFront_reg; // RQ25 RQ15

  wire [15:0] decLinear;
  g711_decoder decoder (
    .code(decodeSource),
    .lawA(lawSelectBit_reg),
    .twosComp(notationSelectBit_reg),
    .linear(decLinear)
  ); // RQ12 RQ13 RQ14

  // Decoder path selector: direct byte or expanded sample
  wire [15:0] port1Read = decoderRouteBit_reg ? decLinear : {8'h00, decodeSource}; // RQ24 RQ8 RQ9 RQ21

  // Register read views
  wire [31:0] controlView = 32'(transmitEnableBit_reg) << g711_pkg::TXEN_BIT
                          | 32'(encoderRouteBit_reg) << g711_pkg::ENC_ROUTE_BIT
                          | 32'(decoderRouteBit_reg) << g711_pkg::DEC_ROUTE_BIT
                          | 32'(lawSelectBit_reg) << g711_pkg::LAW_BIT
                          | 32'(notationSelectBit_reg) << g711_pkg::NOTATION_BIT;
  // Back stage is visible here for diagnosis only, never through port 1
  wire [31:0] statusView = 32'(transmitHoldFront_reg) << g711_pkg::STAT_FRONT_LSB
                         | 32'(transmitHoldBack_reg) << g711_pkg::STAT_BACK_LSB
                         | 32'(shifting) << g711_pkg::STAT_BUSY_BIT;
  wire [31:0] readMux = hitControl ? controlView
                      : hitPort1 ? {16'h0000, port1Read}
                      : hitStatus ? statusView
                      : g711_pkg::WORD_ZERO;

  // APB answer: data captured in setup, pready high for the single access cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= g711_pkg::WORD_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setupPhase;
      pslverr_reg <= setupPhase & ~hitAny;
      if (setupPhase) prdata_reg <= pwrite ? g711_pkg::WORD_ZERO : readMux;
    end
  end

  // Control bits, sign-magnitude after reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      transmitEnableBit_reg <= 1'b0;
      encoderRouteBit_reg <= 1'b0;
      decoderRouteBit_reg <= 1'b0;
      lawSelectBit_reg <= 1'b0;
      notationSelectBit_reg <= 1'b0; // RQ5
    end else if (writeControl) begin
      transmitEnableBit_reg <= pwdata[g711_pkg::TXEN_BIT];
      encoderRouteBit_reg <= pwdata[g711_pkg::ENC_ROUTE_BIT];
      decoderRouteBit_reg <= pwdata[g711_pkg::DEC_ROUTE_BIT];
      lawSelectBit_reg <= pwdata[g711_pkg::LAW_BIT]; // RQ17
      notationSelectBit_reg <= pwdata[g711_pkg::NOTATION_BIT]; // RQ5
    end
  end

  // Two-deep transmit FIFO; a second write pushes the older sample back
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      transmitHoldFront_reg <= g711_pkg::HOLD_RESET;
      transmitHoldBack_reg <= g711_pkg::HOLD_RESET;
    end else if (writePort1) begin
      transmitHoldFront_reg <= frontLoad; // RQ10 RQ11 RQ18
      transmitHoldBack_reg <= transmitHoldFront_reg; // RQ22
    end
  end

  // Serial sequencer
  always_comb begin
    serState_next = serState_reg;
    bitCount_next = bitCount_reg;
    unique case (serState_reg)
      g711_pkg::SER_IDLE: begin
        if (frameStart) begin
          serState_next = g711_pkg::SER_SHIFT;
          bitCount_next = g711_pkg::FRAME_BITS;
        end
      end
      g711_pkg::SER_SHIFT: begin
        if (lastBit) begin
          serState_next = g711_pkg::SER_IDLE;
          bitCount_next = g711_pkg::COUNT_ZERO;
        end else if (sclkFall) begin
          bitCount_next = bitCount_reg - g711_pkg::COUNT_ONE;
        end
      end
      default: begin
        serState_next = g711_pkg::SER_IDLE;
        bitCount_next = g711_pkg::COUNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serState_reg <= g711_pkg::SER_IDLE;
      bitCount_reg <= g711_pkg::COUNT_ZERO;
      sclkPrev_reg <= 1'b0;
      framePrev_reg <= 1'b0;
    end else begin
      serState_reg <= serState_next;
      bitCount_reg <= bitCount_next;
      sclkPrev_reg <= sclk;
      framePrev_reg <= frameSync;
    end
  end

  // Transmit shifters load on the frame, shift on rising serial clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txShift0_reg <= g711_pkg::HOLD_RESET;
      txShift1_reg <= g711_pkg::HOLD_RESET;
      txData0_reg <= 1'b0;
      txData1_reg <= 1'b0;
    end else if (frameStart && !shifting) begin
      txShift0_reg <= transmitHoldFront_reg; // RQ20
      txShift1_reg <= transmitHoldBack_reg;
    end else if (shifting && sclkRise) begin
      txData0_reg <= txShift0_reg[7]; // RQ20
      txData1_reg <= txShift1_reg[7];
      txShift0_reg <= {txShift0_reg[6:0], 1'b0};
      txShift1_reg <= {txShift1_reg[6:0], 1'b0};
    end
  end

  // Pins only driven during a frame with transmit enabled
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txDriveN_reg <= 1'b1;
    end else begin
      txDriveN_reg <= ~(transmitEnableBit_reg & shifting); // RQ26
    end
  end

  // Receive shifter samples on falling serial clock; hold updates after bit 8
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      receiveShift_reg <= g711_pkg::HOLD_RESET;
      receiveHold_reg <= g711_pkg::HOLD_RESET;
    end else if (shifting && sclkFall) begin
      receiveShift_reg <= {receiveShift_reg[6:0], rxData};
      if (lastBit) receiveHold_reg <= {receiveShift_reg[6:0], rxData}; // RQ13 RQ9
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign txData0 = txData0_reg;
  assign txData1 = txData1_reg;
  assign txDriveN = txDriveN_reg;
endmodule // g711_companding_port_unit

// ### g711_companding_port_unit_asserts.sv
// Concurrent checks on the companding port unit's ports
`timescale 1ns/1ns
module g711_companding_port_unit_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial
  input wire logic frameSync,
  input wire logic txDriveN
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [31:0] ctrlReg;
  logic [7:0] frontReg;
  logic [7:0] backReg;
  logic frontOk;
  logic backOk;
  wire wrDone = psel && penable && pready && pwrite;
  wire rdDone = psel && penable && pready && !pwrite;
  // Stage shadow is trusted only while the encoder route was off
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrlReg <= g711_pkg::WORD_ZERO;
      frontReg <= g711_pkg::HOLD_RESET;
      backReg <= g711_pkg::HOLD_RESET;
      frontOk <= 1'b1;
      backOk <= 1'b1;
    end else if (wrDone && paddr == 8'h00) begin
      ctrlReg <= pwdata;
    end else if (wrDone && paddr == 8'h04) begin
      frontReg <= pwdata[7:0];
      backReg <= frontReg;
      frontOk <= !ctrlReg[12];
      backOk <= frontOk;
    end
  end
  sequence setupS;
    psel && !penable;
  endsequence
  sequence accessS;
    psel && penable && pready;
  endsequence
  AST_ACCESS: assert property (setupS |=> accessS)
    else $error("Setup not followed by one access cycle");
  AST_SLVERR: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("Error response does not match address map");
  AST_WRITE_ZERO: assert property (wrDone |-> prdata == g711_pkg::WORD_ZERO)
    else $error("Read data not zero on write");
  AST_CTRL_READ: assert property (rdDone && paddr == 8'h00 |-> prdata == (ctrlReg & 32'h2000_7800))
    else $error("Control readback wrong");
  AST_RAW_READ: assert property (rdDone && paddr == 8'h04 && ctrlReg[13:11] == 3'h0 && frontOk
    |-> prdata == {24'h0, frontReg}) else $error("Raw port read wrong");
  AST_BACK_STATUS: assert property (rdDone && paddr == 8'h08 && frontOk && backOk
    |-> prdata[15:0] == {backReg, frontReg}) else $error("Stage order wrong");
  AST_DRIVE_OFF: assert property (!ctrlReg[11] && !$past(ctrlReg[11]) |-> txDriveN)
    else $error("Serial outputs driven with transmit off");
  AST_FRAME_DRIVE: assert property ($rose(frameSync) && ctrlReg[11] && txDriveN |-> ##[1:3] !txDriveN)
    else $error("Frame did not start driving");
endmodule // g711_companding_port_unit_asserts
bind g711_companding_port_unit g711_companding_port_unit_asserts chk_u (.clk_sys, .reset_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frameSync, .txDriveN);

// ### port1_cpu_model.sv
// Processor-side model issuing port reads and writes over APB
`timescale 1ns/1ns
module port1_cpu_model (
  // Clock
  input wire logic clk_sys,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'hFFFF_FFFF;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e, output logic ok);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 16);
    ok = pready === 1'b1;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not look like the last value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk_sys);
  endtask
  // One write and one read per sample, two idle cycles between them
  task automatic sample(input logic [31:0] d, output logic [31:0] r, output logic ok);
    logic e;
    logic ok1;
    xfer(1'b1, 8'h04, d, r, e, ok1);
    @(posedge clk_sys);
    xfer(1'b0, 8'h04, 32'h0, r, e, ok);
    ok = ok & ok1;
  endtask
endmodule // port1_cpu_model

// ### tb.sv
// Self-checking bench for the companding port unit
`timescale 1ns/1ns
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, txData0, txData1, txDriveN, ok, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sclk = 1'b0, frameSync = 1'b0, rxData = 1'b0, go = 1'b0, done = 1'b0;
  logic [7:0] rxByte = 8'h00, txByte, txByte1;
  logic [15:0] s = 16'h0058;
  int mismatches = 0, n_checks = 0;
  always #25 clk_sys = ~clk_sys;
  g711_companding_port_unit dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk(sclk), .frameSync(frameSync), .rxData(rxData), .txData0(txData0), .txData1(txData1),
    .txDriveN(txDriveN));
  port1_cpu_model cpu_u (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Far-end codec: clock stands still outside frames, MSB first
  always @(posedge go) begin
    done <= 1'b0;
    frameSync <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b1;
      rxData <= rxByte[i];
      repeat (4) @(posedge clk_sys);
      txByte[i] = txData0;
      txByte1[i] = txData1;
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    frameSync <= 1'b0;
    rxData <= ~rxData;
    repeat (4) @(posedge clk_sys);
    done <= 1'b1;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] enc(input logic [15:0] x, input logic a, input logic t);
    int m, sg;
    m = (t && x[15]) ? int'(~x) & 32'h7FFF : int'(x[14:0]);
    sg = 0;
    if (!a) begin
      m = t ? m : m + 33;
      m = m > 8191 ? 8191 : m;
      while (sg < 7 && m >= (64 << sg)) sg++;
      return ~{x[15], sg[2:0], 4'(m >> (sg + 1))};
    end
    m = m > 4095 ? 4095 : m;
    while (sg < 7 && m >= (32 << sg)) sg++;
    return {~x[15], sg[2:0], 4'(m >> (sg == 0 ? 1 : sg))} ^ 8'h55;
  endfunction
  function automatic logic [15:0] dec(input logic [7:0] c, input logic a);
    logic [7:0] v;
    int m;
    v = a ? c ^ 8'h55 : ~c;
    if (!a) m = ((2 * v[3:0] + 33) << v[6:4]) - 33;
    else m = v[6:4] == 0 ? 2 * v[3:0] + 1 : (2 * v[3:0] + 33) << (v[6:4] - 1);
    return {a ? ~v[7] : v[7], 15'(m)};
  endfunction
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic need(input logic good);
    if (good !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    cpu_u.xfer(w, a, d, rd, err, ok);
    need(ok);
  endtask
  task automatic frame();
    int k;
    go <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (done !== 1'b1 && k < 300);
    go <= 1'b0;
    need(done);
  endtask
  initial begin
    logic a;
    logic [1:0] md;
    logic [31:0] cw, ex;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    xf(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    xf(1'b0, 8'h0C, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    xf(1'b1, 8'h04, 32'h0012_34A5);
    xf(1'b1, 8'h04, 32'h0000_003C);
    xf(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_A53C);
    xf(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_003C);
    rxByte = 8'h3E;
    frame();
    // Extremes first so saturation is always hit
    for (int i = 0; i < 24; i++) begin
      a = i[0];
      md = i[2:1];
      s = i == 0 ? 16'h7FFF : i == 1 ? 16'hFFFF : lfsr(s);
      cw = md == 0 ? 32'h1000 : md == 1 ? 32'h3000 : md == 2 ? 32'h2000 : 32'h2000_1000;
      ex = md == 1 ? {16'h0, dec(enc(s, a, 1'b0), a)} : md == 2 ? {16'h0, dec(s[7:0], a)} : {24'h0, enc(s, a, md == 3)};
      xf(1'b1, 8'h00, cw | {17'h0, a, 14'h0});
      cpu_u.sample({16'h0, s}, rd, ok);
      need(ok);
      chk(rd, ex);
    end
    xf(1'b1, 8'h00, 32'h1800);
    xf(1'b1, 8'h04, 32'h0400);
    rxByte = s[7:0] ^ 8'h5A;
    frame();
    chk({24'h0, txByte}, {24'h0, enc(16'h0400, 1'b0, 1'b0)});
    // Back stage holds the last loop sample: A-law, two's complement, encoded
    chk({24'h0, txByte1}, {24'h0, enc(s, 1'b1, 1'b1)});
    xf(1'b0, 8'h04, 32'h0);
    chk(rd, {24'h0, rxByte});
    xf(1'b1, 8'h00, 32'h2800);
    xf(1'b0, 8'h04, 32'h0);
    chk(rd, {16'h0, dec(rxByte, 1'b0)});
    xf(1'b1, 8'h00, 32'h0800);
    xf(1'b0, 8'h04, 32'h0);
    chk(rd, {24'h0, rxByte});
    finish_test();
  end
endmodule // tb
